/* File: rtl/hpp_pkg.sv */
// hpp_pkg: constants and types for the hub port power and strap block.
// assumes a single 100 MHz clock and a classic wishbone register slave.
package hpp_pkg;

    // port count and clocking
    localparam int          HPP_NPORTS         = 4;
    localparam int          HPP_CLK_PERIOD_NS  = 10;
    localparam logic [7:0]  HPP_CLK_MHZ        = 8'h64;
    localparam int          HPP_XTAL_MHZ       = 6;
    localparam int          HPP_PLL_MULT       = 8;
    localparam logic [7:0]  HPP_SAMPLE_MHZ     = 8'(HPP_XTAL_MHZ * HPP_PLL_MULT);
    localparam logic [1:0]  HPP_BUS_DIV_LAST   = 2'h3;

    // over-current filter: least time, rounded up to whole cycles
    localparam int          HPP_OC_FILTER_NS   = 1000;
    localparam logic [7:0]  HPP_OC_FILTER_CYC  =
        8'((HPP_OC_FILTER_NS + HPP_CLK_PERIOD_NS - 1) / HPP_CLK_PERIOD_NS);

    // strap capture waits for the synchroniser to fill
    localparam logic [1:0]  HPP_STRAP_WAIT     = 2'h3;

    // register byte offsets
    localparam logic [3:0]  HPP_OFS_CTRL       = 4'h0;
    localparam logic [3:0]  HPP_OFS_STATUS     = 4'h4;
    localparam logic [3:0]  HPP_OFS_EECTL      = 4'h8;
    localparam logic [3:0]  HPP_OFS_ID         = 4'hc;

    // eeprom control fields
    localparam int          HPP_EE_OWN         = 0;
    localparam int          HPP_EE_SCL         = 1;
    localparam int          HPP_EE_SDA_DRV     = 2;
    localparam int          HPP_EE_SDA_OUT     = 3;

    // values after reset
    localparam logic [3:0]  HPP_RST_PWR_EN_N   = 4'hf;
    localparam logic [3:0]  HPP_RST_OC_SYNC    = 4'hf;
    localparam logic [15:0] HPP_RST_ID         = 16'h0000;

    // block state, one record
    typedef struct packed {
        logic [HPP_NPORTS-1:0]        oc_s1;
        logic [HPP_NPORTS-1:0]        oc_s2;
        logic [2:0]                   strap_s1;
        logic [2:0]                   strap_s2;
        logic [1:0]                   strap_wait;
        logic                         strap_ok;
        logic                         ee_mode;
        logic                         gang;
        logic                         bus_pwr;
        logic [HPP_NPORTS-1:0][7:0]   oc_cnt;
        logic [HPP_NPORTS-1:0]        oc_flt;
        logic [HPP_NPORTS-1:0]        oc_latch;
        logic [HPP_NPORTS-1:0]        pwr_req;
        logic [HPP_NPORTS-1:0]        pwr_en_n;
        logic [HPP_NPORTS-1:0]        low_speed;
        logic [3:0]                   ee_ctl;
        logic                         scl_o;
        logic                         scl_oe_n;
        logic                         sda_o;
        logic                         sda_oe_n;
        logic [15:0]                  custom_id;
        logic [15:0]                  prod_id;
        logic                         suspend;
        logic [7:0]                   acc;
        logic [1:0]                   div;
        logic                         tick48;
        logic                         tick12;
        logic                         ack;
        logic [31:0]                  rdat;
    } hpp_state_s;

endpackage

/* File: rtl/hpp_port_power_config.sv */
// hpp_port_power_config: downstream port power switching, over-current
// filtering, strap capture and eeprom pin sharing for a four-port hub.
// assumes clk_i at 100 MHz, rst_i synchronous, wishbone master on clk_i.
//
// Summary of operation
// - one upstream, four downstream power/over-current ports
// - each port reports full or low speed
// - gang mode drives all enables together
// - gang mode: any over-current powers all off
// - per-port mode: each port acts alone
// - spikes on over-current inputs are filtered
// - memory strap high reports default product id
// - strap high: clock off, data pin gangs
// - strap low: shared pins form eeprom bus
// - eeprom clock is tri-statable for sharing
// - eeprom data pin is bidirectional
// - power strap high bus-powered, low self-powered
// - derive 48 MHz sample, 12 MHz bus timing
// - power enables active low, push-pull
// - reset initializes all internal logic
// - suspend indicator high while suspended
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module hpp_port_power_config #(
    parameter logic [7:0]  OC_FILTER_CYC = hpp_pkg::HPP_OC_FILTER_CYC,
    parameter logic [15:0] DEFAULT_PID   = 16'h1234  // arbitrary value
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // power switch pins
    input  wire logic [3:0]  port_overcurrent_n_i,
    output logic      [3:0]  port_power_enable_n_o,
    // straps
    input  wire logic        external_memory_select_n_i,
    input  wire logic        power_source_select_i,
    // eeprom pins
    output logic             eeprom_serial_clock_o,
    output logic             eeprom_serial_clock_oe_n_o,
    input  wire logic        eeprom_serial_data_i,
    output logic             eeprom_serial_data_o,
    output logic             eeprom_serial_data_oe_n_o,
    // hub core side
    input  wire logic        suspend_req_i,
    input  wire logic [3:0]  port_low_speed_i,
    output logic             suspend_indicator_o,
    output logic             bus_powered_o,
    output logic             gang_mode_o,
    output logic [15:0]      product_id_o,
    output logic             sample_tick_o,
    output logic             bus_tick_o
);

    hpp_pkg::hpp_state_s st_q;
    hpp_pkg::hpp_state_s st_d;

    logic                    req;
    logic                    wr;
    logic [3:0]              oc_set;
    logic [3:0]              oc_clr;
    logic [8:0]              acc_sum;

    always_comb begin
        st_d    = st_q;
        req     = wb_cyc_i & wb_stb_i & ~st_q.ack;
        wr      = req & wb_we_i;
        oc_clr  = 4'h0;
        acc_sum = 9'h000;

        // two-stage synchroniser first
        // raw pin level, nothing reads it before two flops
        st_d.oc_s1    = port_overcurrent_n_i;
        st_d.oc_s2    = st_q.oc_s1;
        st_d.strap_s1 = {eeprom_serial_data_i, power_source_select_i,
                         external_memory_select_n_i};
        st_d.strap_s2 = st_q.strap_s1;

        if (!st_q.strap_ok) begin
            if (st_q.strap_wait == hpp_pkg::HPP_STRAP_WAIT) begin
                st_d.strap_ok = 1'b1;
                st_d.ee_mode  = ~st_q.strap_s2[0];
                st_d.bus_pwr  = st_q.strap_s2[1];
                // data pin doubles as gang strap
                st_d.gang     = st_q.strap_s2[0] & st_q.strap_s2[2];
            end else begin
                st_d.strap_wait = st_q.strap_wait + 2'h1;
            end
        end

        // accept after fixed run of samples
        for (int i = 0; i < hpp_pkg::HPP_NPORTS; i++) begin
            if (!st_q.oc_s2[i]) begin
                if (st_q.oc_cnt[i] == OC_FILTER_CYC) begin
                    st_d.oc_flt[i] = 1'b1;
                end else begin
                    st_d.oc_cnt[i] = st_q.oc_cnt[i] + 8'h01;
                end
            end else begin
                st_d.oc_cnt[i] = 8'h00;
                st_d.oc_flt[i] = 1'b0;
            end
        end

        oc_set = st_q.gang ? {4{|st_q.oc_flt}} : st_q.oc_flt;

        // register writes on byte lane 0, id high byte also on lane 1
        if (wr && wb_sel_i[0]) begin
            case (wb_adr_i)
                hpp_pkg::HPP_OFS_CTRL:   st_d.pwr_req = wb_dat_i[3:0];
                hpp_pkg::HPP_OFS_STATUS: oc_clr       = wb_dat_i[7:4];
                hpp_pkg::HPP_OFS_EECTL:  st_d.ee_ctl  = wb_dat_i[3:0];
                hpp_pkg::HPP_OFS_ID:     st_d.custom_id[7:0] = wb_dat_i[7:0];
                default: ;
            endcase
        end
        if (wr && wb_sel_i[1] && wb_adr_i == hpp_pkg::HPP_OFS_ID) begin
            st_d.custom_id[15:8] = wb_dat_i[15:8];
        end

        // set wins over a software clear
        st_d.oc_latch = (st_q.oc_latch & ~oc_clr) | oc_set;

        // one shared enable in gang mode
        if (!st_q.strap_ok) begin
            st_d.pwr_en_n = hpp_pkg::HPP_RST_PWR_EN_N;
        end else if (st_q.gang) begin
            st_d.pwr_en_n = {4{~(st_q.pwr_req[0] & ~|st_q.oc_latch)}};
        end else begin
            st_d.pwr_en_n = ~(st_q.pwr_req & ~st_q.oc_latch);
        end

        st_d.scl_oe_n = ~(st_q.ee_mode & st_q.ee_ctl[hpp_pkg::HPP_EE_OWN]);
        st_d.scl_o    = st_q.ee_ctl[hpp_pkg::HPP_EE_SCL];
        // data driven or sampled per control
        st_d.sda_oe_n = ~(st_q.ee_mode & st_q.ee_ctl[hpp_pkg::HPP_EE_OWN]
                          & st_q.ee_ctl[hpp_pkg::HPP_EE_SDA_DRV]);
        st_d.sda_o    = st_q.ee_ctl[hpp_pkg::HPP_EE_SDA_OUT];

        // default id unless eeprom supplies one
        st_d.prod_id = st_q.ee_mode ? st_q.custom_id : DEFAULT_PID;

        st_d.suspend   = suspend_req_i;
        // speed of attached device, per port
        st_d.low_speed = port_low_speed_i;

        // fractional divider, 48 then 12
        // jitter of one cycle is the price of a single clock
        acc_sum     = {1'b0, st_q.acc} + {1'b0, hpp_pkg::HPP_SAMPLE_MHZ};
        st_d.tick48 = 1'b0;
        st_d.tick12 = 1'b0;
        if (acc_sum >= {1'b0, hpp_pkg::HPP_CLK_MHZ}) begin
            st_d.acc    = 8'(acc_sum - {1'b0, hpp_pkg::HPP_CLK_MHZ});
            st_d.tick48 = 1'b1;
            st_d.div    = st_q.div + 2'h1;
            st_d.tick12 = (st_q.div == hpp_pkg::HPP_BUS_DIV_LAST);
        end else begin
            st_d.acc = acc_sum[7:0];
        end

        // bus answer one cycle after request, unmapped reads zero
        st_d.ack  = req;
        st_d.rdat = 32'h0000_0000;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                hpp_pkg::HPP_OFS_CTRL:   st_d.rdat[3:0] = st_q.pwr_req;
                hpp_pkg::HPP_OFS_STATUS: st_d.rdat[19:0] = {
                    st_q.low_speed, st_q.suspend, st_q.bus_pwr,
                    st_q.ee_mode, st_q.gang, st_q.oc_flt,
                    st_q.oc_latch, ~st_q.pwr_en_n};
                hpp_pkg::HPP_OFS_EECTL:  st_d.rdat[4:0] = {
                    st_q.strap_s2[2], st_q.ee_ctl};
                hpp_pkg::HPP_OFS_ID:     st_d.rdat[15:0] = st_q.prod_id;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q          <= '0;
            st_q.pwr_en_n <= hpp_pkg::HPP_RST_PWR_EN_N;
            st_q.oc_s1    <= hpp_pkg::HPP_RST_OC_SYNC;
            st_q.oc_s2    <= hpp_pkg::HPP_RST_OC_SYNC;
            st_q.scl_oe_n <= 1'b1;
            st_q.sda_oe_n <= 1'b1;
            st_q.prod_id  <= DEFAULT_PID;
            st_q.custom_id <= hpp_pkg::HPP_RST_ID;
        end else begin
            st_q <= st_d;
        end
    end

    assign wb_dat_o                   = st_q.rdat;
    assign wb_ack_o                   = st_q.ack;
    assign port_power_enable_n_o      = st_q.pwr_en_n;
    assign eeprom_serial_clock_o      = st_q.scl_o;
    assign eeprom_serial_clock_oe_n_o = st_q.scl_oe_n;
    assign eeprom_serial_data_o       = st_q.sda_o;
    assign eeprom_serial_data_oe_n_o  = st_q.sda_oe_n;
    assign suspend_indicator_o        = st_q.suspend;
    assign bus_powered_o              = st_q.bus_pwr;
    assign gang_mode_o                = st_q.gang;
    assign product_id_o               = st_q.prod_id;
    assign sample_tick_o              = st_q.tick48;
    assign bus_tick_o                 = st_q.tick12;

    property p_gang_fault_all_off;
        @(posedge clk_i) disable iff (rst_i)
        (st_q.gang && |st_q.oc_flt) |=> ##1 (port_power_enable_n_o == 4'hf);
    endproperty
    a_gang_fault_all_off: assert property (p_gang_fault_all_off)
        else $error("gang fault left a port powered");

    property p_gang_together;
        @(posedge clk_i) disable iff (rst_i)
        st_q.gang |-> (&port_power_enable_n_o || ~|port_power_enable_n_o);
    endproperty
    a_gang_together: assert property (p_gang_together)
        else $error("gang enables differ");

    property p_port_isolated;
        @(posedge clk_i) disable iff (rst_i)
        (!st_q.gang && st_q.strap_ok && st_q.oc_flt[0] && !st_q.oc_latch[1]
         && st_q.pwr_req[1] && !st_q.oc_flt[1]) |=> ##1 !port_power_enable_n_o[1];
    endproperty
    a_port_isolated: assert property (p_port_isolated)
        else $error("fault on port 0 reached port 1");

    property p_spike_rejected;
        @(posedge clk_i) disable iff (rst_i)
        st_q.oc_s2[0] |=> !st_q.oc_flt[0];
    endproperty
    a_spike_rejected: assert property (p_spike_rejected)
        else $error("filtered flag outlived input");

    property p_filter_count;
        @(posedge clk_i) disable iff (rst_i)
        $rose(st_q.oc_flt[0]) |->
            ($past(st_q.oc_cnt[0]) == OC_FILTER_CYC) && !$past(st_q.oc_s2[0]);
    endproperty
    a_filter_count: assert property (p_filter_count)
        else $error("over-current accepted early");

    property p_pins_idle_no_eeprom;
        @(posedge clk_i) disable iff (rst_i)
        (st_q.strap_ok && !st_q.ee_mode) |=>
            (eeprom_serial_clock_oe_n_o && eeprom_serial_data_oe_n_o);
    endproperty
    a_pins_idle_no_eeprom: assert property (p_pins_idle_no_eeprom)
        else $error("eeprom pin driven with memory off");

    property p_straps_held;
        @(posedge clk_i) disable iff (rst_i)
        $past(st_q.strap_ok) |-> ($stable(st_q.gang) && $stable(st_q.ee_mode)
                                  && $stable(bus_powered_o));
    endproperty
    a_straps_held: assert property (p_straps_held)
        else $error("strap value changed after capture");

    property p_suspend_follows;
        @(posedge clk_i) disable iff (rst_i)
        suspend_req_i |=> suspend_indicator_o;
    endproperty
    a_suspend_follows: assert property (p_suspend_follows)
        else $error("suspend indicator late");

    property p_bus_tick_rate;
        @(posedge clk_i) disable iff (rst_i)
        bus_tick_o |=> !bus_tick_o [*7];
    endproperty
    a_bus_tick_rate: assert property (p_bus_tick_rate)
        else $error("bus tick too frequent");

    property p_default_id;
        @(posedge clk_i) disable iff (rst_i)
        (st_q.strap_ok && !st_q.ee_mode) |=> (product_id_o == DEFAULT_PID);
    endproperty
    a_default_id: assert property (p_default_id)
        else $error("default id not shown");

    property p_enables_off_early;
        @(posedge clk_i) disable iff (rst_i)
        !st_q.strap_ok |=> (port_power_enable_n_o == hpp_pkg::HPP_RST_PWR_EN_N);
    endproperty
    a_enables_off_early: assert property (p_enables_off_early)
        else $error("port powered before straps captured");

    property p_power_strap;
        @(posedge clk_i) disable iff (rst_i)
        $rose(st_q.strap_ok) |-> (bus_powered_o == $past(st_q.strap_s2[1])) &&
            (st_q.ee_mode == !$past(st_q.strap_s2[0]));
    endproperty
    a_power_strap: assert property (p_power_strap)
        else $error("strap captured wrongly");

    property p_fault_latched;
        @(posedge clk_i) disable iff (rst_i)
        st_q.oc_flt[0] |=> st_q.oc_latch[0];
    endproperty
    a_fault_latched: assert property (p_fault_latched)
        else $error("filtered fault not latched");

    property p_latched_port_off;
        @(posedge clk_i) disable iff (rst_i)
        (st_q.strap_ok && !st_q.gang && st_q.oc_latch[0]) |=> port_power_enable_n_o[0];
    endproperty
    a_latched_port_off: assert property (p_latched_port_off)
        else $error("faulted port left powered");

    property p_sample_tick_gap;
        @(posedge clk_i) disable iff (rst_i)
        sample_tick_o |=> !sample_tick_o;
    endproperty
    a_sample_tick_gap: assert property (p_sample_tick_gap)
        else $error("sample tick too frequent");

    property p_clock_driven;
        @(posedge clk_i) disable iff (rst_i)
        (st_q.ee_mode && st_q.ee_ctl[hpp_pkg::HPP_EE_OWN]) |=> !eeprom_serial_clock_oe_n_o;
    endproperty
    a_clock_driven: assert property (p_clock_driven)
        else $error("owned eeprom clock not driven");

endmodule // hpp_port_power_config

`default_nettype wire

/* File: tb/hpp_switch_model.sv */
// hpp_switch_model: power switches and the shared data pin.
// assumes the bench commands faults and straps on clk_i.
`timescale 1ns/1ps
`default_nettype none

module hpp_switch_model (
    // bench control
    input  wire logic       clk_i,
    input  wire logic [3:0] fault_i,
    input  wire logic       gang_strap_i,
    input  wire logic       ee_mode_i,
    // device pins
    input  wire logic [3:0] pwr_en_n_i,
    output logic      [3:0] oc_n_o,
    input  wire logic       sda_i,
    input  wire logic       sda_oe_n_i,
    output logic            sda_pin_o
);
    // fault pulls low
    // only a powered port can trip
    always_ff @(posedge clk_i) begin
        oc_n_o <= ~(fault_i & ~pwr_en_n_i);
    end
    assign sda_pin_o = !sda_oe_n_i ? sda_i : (ee_mode_i ? 1'b0 : gang_strap_i);
endmodule // hpp_switch_model

`default_nettype wire

/* File: tb/hpp_port_power_config_tb.sv */
// hpp_port_power_config_tb: wishbone tasks and port power scenarios.
// assumes the switch model on the power and data pins.
`timescale 1ns/1ps
`default_nettype none

module hpp_port_power_config_tb;
    logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
    logic [3:0]  adr = 0, sel = 0, oc_n, pen_n, fault = 0, ls = 4'h9;
    logic [31:0] wdat = 0, rdat, r;
    logic        ack, ext_n = 1, psrc = 0, gstrap = 0, sreq = 0, sclk, sclk_oe_n;
    logic        sda_pin, sda_out, sda_oe_n, susp, bpw, gang, stick, btick;
    logic [15:0] pid;
    int          err_total = 0, num_checks = 0, ns, nb;

    always #5 clk_i = ~clk_i;

    hpp_port_power_config #(.OC_FILTER_CYC(8'h04)) hpp_port_power_config_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .port_overcurrent_n_i(oc_n),
        .port_power_enable_n_o(pen_n), .external_memory_select_n_i(ext_n),
        .power_source_select_i(psrc), .eeprom_serial_clock_o(sclk),
        .eeprom_serial_clock_oe_n_o(sclk_oe_n), .eeprom_serial_data_i(sda_pin),
        .eeprom_serial_data_o(sda_out), .eeprom_serial_data_oe_n_o(sda_oe_n),
        .suspend_req_i(sreq), .port_low_speed_i(ls), .suspend_indicator_o(susp),
        .bus_powered_o(bpw), .gang_mode_o(gang), .product_id_o(pid),
        .sample_tick_o(stick), .bus_tick_o(btick));

    hpp_switch_model hpp_switch_model_inst (
        .clk_i(clk_i), .fault_i(fault), .gang_strap_i(gstrap), .ee_mode_i(~ext_n),
        .pwr_en_n_i(pen_n), .oc_n_o(oc_n), .sda_i(sda_out),
        .sda_oe_n_i(sda_oe_n), .sda_pin_o(sda_pin));

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (e !== g) begin
            err_total++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one classic cycle, held until ack is sampled
    task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= s; wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = rdat;
        cyc <= 0; stb <= 0; we <= 0;
        if (n >= 50) chk("ack", 1, 0);
    endtask

    task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] e);
        bus(0, a, 4'h1, 0);
        chk(nm, e, r);
    endtask

    task automatic do_rst(input logic e, input logic p, input logic g);
        @(posedge clk_i);
        rst_i <= 1; ext_n <= e; psrc <= p; gstrap <= g;
        wt(20);
        chk("pwr_en_n rst", 4'hf, pen_n);
        chk("clk oe_n rst", 1, sclk_oe_n);
        rst_i <= 0;
        wt(8);
    endtask

    task automatic trip(input logic [3:0] f, input int n);
        @(posedge clk_i);
        fault <= f;
        wt(n);
        fault <= 0;
        wt(12);
    endtask

    initial begin
        #400000;
        err_total++;
        test_done();
    end

    initial begin
        do_rst(1, 0, 0);
        chk("bus_pwr", 0, bpw);
        chk("gang", 0, gang);
        chk("pid", 16'h1234, pid);
        chk("clk oe_n", 1, sclk_oe_n);
        bus(1, 4'h0, 4'h1, 32'h7);
        wt(2);
        chk("pwr_en_n", 4'h8, pen_n);
        // a spike one sample short of the filter
        trip(4'h1, 4);
        chk("pwr_en_n spike", 4'h8, pen_n);
        trip(4'h1, 20);
        chk("pwr_en_n trip", 4'h9, pen_n);
        rdc("status", 4'h4, 32'h00090016);
        bus(1, 4'h4, 4'h1, 32'h10);
        bus(1, 4'h0, 4'h1, 32'hf);
        rdc("status clr", 4'h4, 32'h0009000f);
        bus(1, 4'h2, 4'h1, 32'h0);
        rdc("unmapped", 4'h2, 0);
        rdc("ctrl", 4'h0, 32'hf);
        @(posedge clk_i);
        sreq <= 1;
        wt(3);
        chk("suspend", 1, susp);
        rdc("status susp", 4'h4, 32'h0009800f);
        sreq <= 0;
        wt(3);
        chk("suspend off", 0, susp);
        ns = 0;
        nb = 0;
        repeat (400) begin
            @(posedge clk_i);
            ns += (stick === 1'b1);
            nb += (btick === 1'b1);
        end
        chk("tick48", 1, ns >= 191 && ns <= 193);
        chk("tick12", 1, nb >= 47 && nb <= 49);
        do_rst(1, 1, 1);
        chk("bus_pwr", 1, bpw);
        chk("gang", 1, gang);
        bus(1, 4'h0, 4'h1, 32'h1);
        wt(2);
        chk("gang on", 4'h0, pen_n);
        trip(4'h4, 20);
        chk("gang trip", 4'hf, pen_n);
        @(posedge clk_i);
        gstrap <= 0;
        wt(10);
        chk("gang held", 1, gang);
        do_rst(0, 0, 1);
        chk("ee gang", 0, gang);
        bus(1, 4'h8, 4'h1, 32'hf);
        wt(2);
        chk("ee pins", 4'b0101, {sclk_oe_n, sclk, sda_oe_n, sda_out});
        bus(1, 4'h8, 4'h1, 32'h1);
        wt(4);
        rdc("eectl low", 4'h8, 32'h1);
        bus(1, 4'h8, 4'h1, 32'hd);
        wt(4);
        rdc("eectl high", 4'h8, 32'h1d);
        bus(1, 4'h8, 4'h1, 32'h0);
        wt(2);
        chk("clk released", 1, sclk_oe_n);
        bus(1, 4'hc, 4'h3, 32'hbeef);
        wt(2);
        chk("pid custom", 16'hbeef, pid);
        rdc("id", 4'hc, 32'hbeef);
        test_done();
    end
endmodule // hpp_port_power_config_tb

`default_nettype wire
